//--- src/ofd_decoder.sv
`timescale 1ns/100ps
`include "ofd_params.svh"

module ofd_decoder (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction bytes and context from prefetch.
  input wire logic valid_i,
  input wire logic addr32_i,
  input wire logic op32_i,
  input wire logic w_present_i,
  input wire logic w_i,
  input wire logic [7:0] modrm_i,
  input wire logic [7:0] sib_i,
  input wire logic [2:0] wide_segment_selector_i,
  input wire logic [1:0] legacy_segment_selector_i,
  input wire logic [31:0] index_value_i,
  // Decoded selections for the register file and address generation.
  output logic valid_o,
  output logic rm_is_reg_o,
  output logic [2:0] rm_num_o,
  output logic rm_high_o,
  output ofd_pkg::ofd_size_e rm_size_o,
  output logic [2:0] reg_num_o,
  output logic reg_high_o,
  output ofd_pkg::ofd_size_e reg_size_o,
  output ofd_pkg::ofd_seg_e wide_seg_o,
  output logic wide_seg_undef_o,
  output ofd_pkg::ofd_seg_e legacy_seg_o,
  output logic sib_follows_o,
  output logic [3:0] scale_o,
  output logic index_used_o,
  output logic [2:0] index_num_o,
  output logic [31:0] scaled_index_o,
  output logic base_used_o,
  output logic [2:0] base_num_o,
  output ofd_pkg::ofd_disp_e disp_o,
  output ofd_pkg::ofd_seg_e default_seg_o
);

  // Field views.
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic [2:0] rm_f;
  logic [1:0] ss_f;
  logic [2:0] idx_f;
  logic [2:0] base_f;

  assign mod_f = modrm_i[`OFD_MOD_HI:`OFD_MOD_LO];
  assign reg_f = modrm_i[`OFD_REG_HI:`OFD_REG_LO];
  assign rm_f = modrm_i[`OFD_RM_HI:`OFD_RM_LO];
  assign ss_f = sib_i[`OFD_SS_HI:`OFD_SS_LO];
  assign idx_f = sib_i[`OFD_IDX_HI:`OFD_IDX_LO];
  assign base_f = sib_i[`OFD_BASE_HI:`OFD_BASE_LO];

  // Next values of the registered outputs.
  logic rm_is_reg_nxt;
  logic [2:0] rm_num_nxt;
  logic rm_high_nxt;
  ofd_pkg::ofd_size_e rm_size_nxt;
  logic [2:0] reg_num_nxt;
  logic reg_high_nxt;
  ofd_pkg::ofd_size_e reg_size_nxt;
  ofd_pkg::ofd_seg_e wide_seg_nxt;
  logic wide_seg_undef_nxt;
  ofd_pkg::ofd_seg_e legacy_seg_nxt;
  logic sib_follows_nxt;
  logic [3:0] scale_nxt;
  logic index_used_nxt;
  logic [2:0] index_num_nxt;
  logic [31:0] scaled_index_nxt;
  logic base_used_nxt;
  logic [2:0] base_num_nxt;
  ofd_pkg::ofd_disp_e disp_nxt;
  ofd_pkg::ofd_seg_e default_seg_nxt;

  // Raw register picks; the locator pick is only meaningful in form 11.
  logic [2:0] rm_pick_num;
  logic rm_pick_high;
  ofd_pkg::ofd_size_e rm_pick_size;

  // Register operand named by the locator in register-direct form.
  ofd_reg_select u_rm_select (
    .code_i(rm_f),
    .w_present_i(w_present_i),
    .w_i(w_i),
    .op32_i(op32_i),
    .num_o(rm_pick_num),
    .high_o(rm_pick_high),
    .size_o(rm_pick_size)
  );

  // Register operand named by the general register selector.
  ofd_reg_select u_reg_select (
    .code_i(reg_f),
    .w_present_i(w_present_i),
    .w_i(w_i),
    .op32_i(op32_i),
    .num_o(reg_num_nxt),
    .high_o(reg_high_nxt),
    .size_o(reg_size_nxt)
  );

  // Register-direct operand is reported only in form 11, zero otherwise.
  always_comb begin
    rm_is_reg_nxt = (mod_f == `OFD_MOD_REG);
    rm_num_nxt = rm_is_reg_nxt ? rm_pick_num : 3'h0;
    rm_high_nxt = rm_is_reg_nxt ? rm_pick_high : 1'b0;
    rm_size_nxt = rm_is_reg_nxt ? rm_pick_size : ofd_pkg::OFD_SZ8;
  end

  // Segment selectors; codes 6 and 7 get a flag and ES so nothing is left floating.
  always_comb begin
    wide_seg_undef_nxt = 1'b0;
    case (wide_segment_selector_i)
      `OFD_SEG3_ES: wide_seg_nxt = ofd_pkg::OFD_SEG_ES;
      `OFD_SEG3_CS: wide_seg_nxt = ofd_pkg::OFD_SEG_CS;
      `OFD_SEG3_SS: wide_seg_nxt = ofd_pkg::OFD_SEG_SS;
      `OFD_SEG3_DS: wide_seg_nxt = ofd_pkg::OFD_SEG_DS;
      `OFD_SEG3_FS: wide_seg_nxt = ofd_pkg::OFD_SEG_FS;
      `OFD_SEG3_GS: wide_seg_nxt = ofd_pkg::OFD_SEG_GS;
      default: begin
        wide_seg_nxt = ofd_pkg::OFD_SEG_ES;
        wide_seg_undef_nxt = 1'b1;
      end
    endcase
    case (legacy_segment_selector_i)
      `OFD_SEG2_ES: legacy_seg_nxt = ofd_pkg::OFD_SEG_ES;
      `OFD_SEG2_CS: legacy_seg_nxt = ofd_pkg::OFD_SEG_CS;
      `OFD_SEG2_SS: legacy_seg_nxt = ofd_pkg::OFD_SEG_SS;
      default: legacy_seg_nxt = ofd_pkg::OFD_SEG_DS;
    endcase
  end

  // Scaled-index byte decode; when no such byte follows, all fields read zero and the default segment reads DS.
  always_comb begin
    sib_follows_nxt = addr32_i && (mod_f != `OFD_MOD_REG) && (rm_f == `OFD_RM_SIB);
    scale_nxt = 4'h0;
    index_used_nxt = 1'b0;
    index_num_nxt = 3'h0;
    scaled_index_nxt = 32'h0000_0000;
    base_used_nxt = 1'b0;
    base_num_nxt = 3'h0;
    disp_nxt = ofd_pkg::OFD_DISP_NONE;
    default_seg_nxt = ofd_pkg::OFD_SEG_DS;
    if (sib_follows_nxt) begin
      case (ss_f)
        `OFD_SS_X1: scale_nxt = `OFD_FACTOR_1;
        `OFD_SS_X2: scale_nxt = `OFD_FACTOR_2;
        `OFD_SS_X4: scale_nxt = `OFD_FACTOR_4;
        default: scale_nxt = `OFD_FACTOR_8;
      endcase
      // A nonzero scale with no index is the encoder's fault; the term stays zero.
      index_used_nxt = (idx_f != `OFD_IDX_NONE);
      index_num_nxt = index_used_nxt ? idx_f : 3'h0;
      // A shift replaces the multiplier since every factor is a power of two.
      scaled_index_nxt = index_used_nxt ? (index_value_i << ss_f) : 32'h0000_0000;
      // Mode comes from form and base, never from the plain locator.
      base_used_nxt = !((mod_f == `OFD_MOD_NODISP) && (base_f == `OFD_BASE_FRAME));
      base_num_nxt = base_used_nxt ? base_f : 3'h0;
      case (mod_f)
        `OFD_MOD_D8: disp_nxt = ofd_pkg::OFD_DISP_8;
        `OFD_MOD_D32: disp_nxt = ofd_pkg::OFD_DISP_32;
        default: disp_nxt = base_used_nxt ? ofd_pkg::OFD_DISP_NONE : ofd_pkg::OFD_DISP_32;
      endcase
      if ((base_f == `OFD_BASE_STACK) || ((base_f == `OFD_BASE_FRAME) && (mod_f != `OFD_MOD_NODISP))) begin
        default_seg_nxt = ofd_pkg::OFD_SEG_SS;
      end
    end
  end

  // Valid marker follows the request by one cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
    end
  end

  // Register operand outputs; held when no request so consumers see stable values.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rm_is_reg_o <= 1'b0;
      rm_num_o <= 3'h0;
      rm_high_o <= 1'b0;
      rm_size_o <= ofd_pkg::OFD_SZ8;
      reg_num_o <= 3'h0;
      reg_high_o <= 1'b0;
      reg_size_o <= ofd_pkg::OFD_SZ8;
    end else if (valid_i) begin
      rm_is_reg_o <= rm_is_reg_nxt;
      rm_num_o <= rm_num_nxt;
      rm_high_o <= rm_high_nxt;
      rm_size_o <= rm_size_nxt;
      reg_num_o <= reg_num_nxt;
      reg_high_o <= reg_high_nxt;
      reg_size_o <= reg_size_nxt;
    end
  end

  // Segment selector outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wide_seg_o <= ofd_pkg::OFD_SEG_ES;
      wide_seg_undef_o <= 1'b0;
      legacy_seg_o <= ofd_pkg::OFD_SEG_ES;
    end else if (valid_i) begin
      wide_seg_o <= wide_seg_nxt;
      wide_seg_undef_o <= wide_seg_undef_nxt;
      legacy_seg_o <= legacy_seg_nxt;
    end
  end

  // Effective-address outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sib_follows_o <= 1'b0;
      scale_o <= 4'h0;
      index_used_o <= 1'b0;
      index_num_o <= 3'h0;
      scaled_index_o <= 32'h0000_0000;
      base_used_o <= 1'b0;
      base_num_o <= 3'h0;
      disp_o <= ofd_pkg::OFD_DISP_NONE;
      default_seg_o <= ofd_pkg::OFD_SEG_DS;
    end else if (valid_i) begin
      sib_follows_o <= sib_follows_nxt;
      scale_o <= scale_nxt;
      index_used_o <= index_used_nxt;
      index_num_o <= index_num_nxt;
      scaled_index_o <= scaled_index_nxt;
      base_used_o <= base_used_nxt;
      base_num_o <= base_num_nxt;
      disp_o <= disp_nxt;
      default_seg_o <= default_seg_nxt;
    end
  end

endmodule : ofd_decoder

//--- src/ofd_params.svh
`ifndef OFD_PARAMS_SVH
`define OFD_PARAMS_SVH

// Field positions inside the addressing byte.
`define OFD_MOD_HI 7
`define OFD_MOD_LO 6
`define OFD_REG_HI 5
`define OFD_REG_LO 3
`define OFD_RM_HI 2
`define OFD_RM_LO 0

// Field positions inside the scaled-index byte.
`define OFD_SS_HI 7
`define OFD_SS_LO 6
`define OFD_IDX_HI 5
`define OFD_IDX_LO 3
`define OFD_BASE_HI 2
`define OFD_BASE_LO 0

// Addressing form codes.
`define OFD_MOD_NODISP 2'h0
`define OFD_MOD_D8 2'h1
`define OFD_MOD_D32 2'h2
`define OFD_MOD_REG 2'h3

// Special locator, index and base codes.
`define OFD_RM_SIB 3'h4
`define OFD_IDX_NONE 3'h4
`define OFD_BASE_STACK 3'h4
`define OFD_BASE_FRAME 3'h5

// Bit of a byte register code that picks the high byte.
`define OFD_HIGH_BIT 2

// Scale selector codes and the factors they give.
`define OFD_SS_X1 2'h0
`define OFD_SS_X2 2'h1
`define OFD_SS_X4 2'h2
`define OFD_SS_X8 2'h3
`define OFD_FACTOR_1 4'h1
`define OFD_FACTOR_2 4'h2
`define OFD_FACTOR_4 4'h4
`define OFD_FACTOR_8 4'h8

// Segment selector codes.
`define OFD_SEG3_ES 3'h0
`define OFD_SEG3_CS 3'h1
`define OFD_SEG3_SS 3'h2
`define OFD_SEG3_DS 3'h3
`define OFD_SEG3_FS 3'h4
`define OFD_SEG3_GS 3'h5
`define OFD_SEG2_ES 2'h0
`define OFD_SEG2_CS 2'h1
`define OFD_SEG2_SS 2'h2
`define OFD_SEG2_DS 2'h3

`endif

//--- src/ofd_pkg.sv
package ofd_pkg;

  // Segment register selections.
  typedef enum logic [2:0] {
    OFD_SEG_ES,
    OFD_SEG_CS,
    OFD_SEG_SS,
    OFD_SEG_DS,
    OFD_SEG_FS,
    OFD_SEG_GS
  } ofd_seg_e;

  // Operand widths.
  typedef enum logic [1:0] {
    OFD_SZ8,
    OFD_SZ16,
    OFD_SZ32
  } ofd_size_e;

  // Displacement sizes for scaled-index addressing.
  typedef enum logic [1:0] {
    OFD_DISP_NONE,
    OFD_DISP_8,
    OFD_DISP_32
  } ofd_disp_e;

endpackage : ofd_pkg

//--- src/ofd_reg_select.sv
`timescale 1ns/100ps
`include "ofd_params.svh"

module ofd_reg_select (
  // Register code and size context.
  input wire logic [2:0] code_i,
  input wire logic w_present_i,
  input wire logic w_i,
  input wire logic op32_i,
  // Selected register.
  output logic [2:0] num_o,
  output logic high_o,
  output ofd_pkg::ofd_size_e size_o
);

  // A byte pick folds codes 4-7 onto the high bytes of registers 0-3.
  always_comb begin
    if (w_present_i && !w_i) begin
      num_o = {1'b0, code_i[1:0]};
      high_o = code_i[`OFD_HIGH_BIT];
      size_o = ofd_pkg::OFD_SZ8;
    end else begin
      num_o = code_i;
      high_o = 1'b0;
      size_o = op32_i ? ofd_pkg::OFD_SZ32 : ofd_pkg::OFD_SZ16;
    end
  end

endmodule : ofd_reg_select

//--- verif/ofd_decoder_monitor.sv
`timescale 1ns/100ps
module ofd_decoder_monitor (
  // Clock, reset and request.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic addr32_i,
  input wire logic op32_i,
  input wire logic w_present_i,
  input wire logic w_i,
  input wire logic [7:0] modrm_i,
  input wire logic [7:0] sib_i,
  input wire logic [2:0] wide_segment_selector_i,
  input wire logic [1:0] legacy_segment_selector_i,
  input wire logic [31:0] index_value_i,
  // Decoded selections.
  input wire logic valid_o,
  input wire logic rm_is_reg_o,
  input wire logic [2:0] rm_num_o,
  input wire logic rm_high_o,
  input ofd_pkg::ofd_size_e rm_size_o,
  input wire logic [2:0] reg_num_o,
  input wire logic reg_high_o,
  input ofd_pkg::ofd_size_e reg_size_o,
  input ofd_pkg::ofd_seg_e wide_seg_o,
  input wire logic wide_seg_undef_o,
  input ofd_pkg::ofd_seg_e legacy_seg_o,
  input wire logic sib_follows_o,
  input wire logic [3:0] scale_o,
  input wire logic index_used_o,
  input wire logic [2:0] index_num_o,
  input wire logic [31:0] scaled_index_o,
  input wire logic base_used_o,
  input wire logic [2:0] base_num_o,
  input ofd_pkg::ofd_disp_e disp_o,
  input ofd_pkg::ofd_seg_e default_seg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A memory form with locator 100 in 32-bit mode, and a byte register request.
  sequence sib_req;
    valid_i && addr32_i && modrm_i[7:6] != 2'h3 && modrm_i[2:0] == 3'h4;
  endsequence
  sequence byte_req;
    valid_i && modrm_i[7:6] == 2'h3 && w_present_i && !w_i;
  endsequence
  // Every check looks one edge after the request, as the latency is fixed.
  chk_valid_delay: assert property (valid_i |=> valid_o) else $error("valid_o missing");
  chk_rm_byte: assert property (byte_req |=> rm_is_reg_o && rm_size_o == ofd_pkg::OFD_SZ8 &&
    rm_num_o == {1'b0, $past(modrm_i[1:0])} && rm_high_o == $past(modrm_i[2])) else $error("byte register wrong");
  chk_reg_full: assert property (valid_i && !w_present_i |=>
    reg_num_o == $past(modrm_i[5:3]) &&
    !reg_high_o && reg_size_o == ($past(op32_i) ? ofd_pkg::OFD_SZ32 : ofd_pkg::OFD_SZ16)) else $error("reg wrong");
  chk_wide_seg: assert property (valid_i && wide_segment_selector_i < 3'h6 |=>
    wide_seg_o == $past(wide_segment_selector_i) && !wide_seg_undef_o) else $error("wide segment wrong");
  chk_legacy_seg: assert property (valid_i |=>
    legacy_seg_o == {1'b0, $past(legacy_segment_selector_i)}) else $error("legacy segment wrong");
  chk_scale_factor: assert property (sib_req |=>
    sib_follows_o && scale_o == 4'h1 << $past(sib_i[7:6])) else $error("scale wrong");
  chk_index_scaled: assert property (sib_req ##0 sib_i[5:3] != 3'h4 |=>
    index_used_o && index_num_o == $past(sib_i[5:3]) &&
    scaled_index_o == $past(index_value_i) * (32'h1 << $past(sib_i[7:6])))
    else $error("scaled index wrong");
  chk_index_none: assert property (sib_req ##0 sib_i[5:3] == 3'h4 |=>
    !index_used_o && scaled_index_o == 32'h0) else $error("unused index contributes");
  // Form 00 with base 101 swaps the base register for a 32-bit displacement.
  chk_disp_base: assert property (sib_req |=>
    disp_o == (($past(modrm_i[7:6]) == 2'h0 && $past(sib_i[2:0]) == 3'h5) ? 2'h2 : $past(modrm_i[7:6])) &&
    base_used_o == ($past(modrm_i[7:6]) != 2'h0 || $past(sib_i[2:0]) != 3'h5)) else $error("disp or base wrong");
  chk_default_seg: assert property (sib_req |=> default_seg_o == (($past(sib_i[2:0]) == 3'h4 ||
    ($past(sib_i[2:0]) == 3'h5 && $past(modrm_i[7:6]) != 2'h0)) ? ofd_pkg::OFD_SEG_SS : ofd_pkg::OFD_SEG_DS))
    else $error("default segment wrong");
endmodule : ofd_decoder_monitor

bind ofd_decoder ofd_decoder_monitor ofd_decoder_monitor_inst (.*);

//--- verif/ofd_regfile_model.sv
`timescale 1ns/100ps
module ofd_regfile_model (
  // Scaled-index byte whose index field names the register.
  input wire logic [7:0] sib_i,
  // Value of the named register.
  output logic [31:0] index_value_o
);
  // High bits are set so that a lost or kept carry out of the shift shows.
  assign index_value_o = 32'hc3a5_5a81 ^ {26'h0, sib_i[5:3], sib_i[5:3]};
endmodule : ofd_regfile_model

//--- verif/ofd_decoder_tb_top.sv
`timescale 1ns/100ps
module ofd_decoder_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic valid_i = 1'b0, addr32_i = 1'b0, op32_i = 1'b0, w_present_i = 1'b0, w_i = 1'b0;
  logic [7:0] modrm_i = 8'h00, sib_i = 8'h00;
  logic [2:0] wide_segment_selector_i = 3'h0;
  logic [1:0] legacy_segment_selector_i = 2'h0;
  logic [31:0] index_value_i;
  logic valid_o, rm_is_reg_o, rm_high_o, reg_high_o, wide_seg_undef_o, sib_follows_o, index_used_o, base_used_o;
  logic [2:0] rm_num_o, reg_num_o, index_num_o, base_num_o;
  logic [3:0] scale_o;
  logic [31:0] scaled_index_o;
  ofd_pkg::ofd_size_e rm_size_o, reg_size_o;
  ofd_pkg::ofd_seg_e wide_seg_o, legacy_seg_o, default_seg_o;
  ofd_pkg::ofd_disp_e disp_o;
  int err_count = 0;
  int checked = 0;
  ofd_decoder ofd_decoder_inst (.*);
  ofd_regfile_model ofd_regfile_model_inst (.sib_i(sib_i), .index_value_o(index_value_i));
  // Free-running core clock.
  always #4 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One request cycle; outputs are settled a step after the edge that takes it.
  task automatic send(input logic a, input logic o, input logic p, input logic w, input logic [7:0] m,
    input logic [7:0] s, input logic [2:0] ws, input logic [1:0] ls);
    @(posedge clk_i);
    valid_i <= 1'b1;
    addr32_i <= a;
    op32_i <= o;
    w_present_i <= p;
    w_i <= w;
    modrm_i <= m;
    sib_i <= s;
    wide_segment_selector_i <= ws;
    legacy_segment_selector_i <= ls;
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1;
    chk("valid_o", 1'b1, valid_o);
  endtask : send
  task automatic t_rm;
    for (int c = 0; c < 8; c++) begin
      send(1'b0, 1'b1, 1'b1, 1'b0, {5'h18, 3'(c)}, 8'h00, 3'h0, 2'h0);
      chk("rm_is_reg_o", 1'b1, rm_is_reg_o);
      chk("rm_num_o", c % 4, rm_num_o);
      chk("rm_high_o", c / 4, rm_high_o);
      chk("rm_size_o", ofd_pkg::OFD_SZ8, rm_size_o);
      send(1'b0, 1'b1, 1'b1, 1'b1, {5'h18, 3'(c)}, 8'h00, 3'h0, 2'h0);
      chk("rm_num_o", c, rm_num_o);
      chk("rm_size_o", ofd_pkg::OFD_SZ32, rm_size_o);
    end
  endtask : t_rm
  task automatic t_reg;
    for (int c = 0; c < 16; c++) begin
      send(1'b0, c[3], 1'b0, 1'b0, {2'h0, 3'(c), 3'h0}, 8'h00, 3'h0, 2'h0);
      chk("reg_num_o", c % 8, reg_num_o);
      chk("reg_size_o", c[3] ? ofd_pkg::OFD_SZ32 : ofd_pkg::OFD_SZ16, reg_size_o);
      send(1'b0, 1'b0, 1'b1, 1'b0, {2'h0, 3'(c), 3'h0}, 8'h00, 3'h0, 2'h0);
      chk("reg_high_o", c[2], reg_high_o);
    end
  endtask : t_reg
  task automatic t_seg;
    for (int c = 0; c < 8; c++) begin
      send(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 3'(c), 2'(c));
      chk("wide_seg_undef_o", c > 5, wide_seg_undef_o);
      if (c < 6) chk("wide_seg_o", c, wide_seg_o);
      chk("legacy_seg_o", c % 4, legacy_seg_o);
    end
  endtask : t_seg
  task automatic t_sib;
    logic [2:0] ix;
    logic [1:0] s;
    for (int f = 0; f < 3; f++) begin
      for (int q = 0; q < 32; q++) begin
        ix = 3'(q / 8 + q);
        s = (ix == 3'h4) ? 2'h0 : 2'(q / 8);
        send(1'b1, 1'b1, 1'b0, 1'b0, {2'(f), 6'h14}, {s, ix, 3'(q)}, 3'h0, 2'h0);
        chk("sib_follows_o", 1'b1, sib_follows_o);
        chk("rm_is_reg_o", 1'b0, rm_is_reg_o);
        chk("scale_o", 4'h1 << s, scale_o);
        chk("scaled_index_o", (ix == 3'h4) ? 32'h0 : index_value_i * (32'h1 << s), scaled_index_o);
        chk("index_used_o", ix != 3'h4, index_used_o);
        chk("base_num_o", (f == 0 && q % 8 == 5) ? 0 : q % 8, base_num_o);
        chk("disp_o", (f == 0 && q % 8 == 5) ? 32'(ofd_pkg::OFD_DISP_32) : 32'(f), disp_o);
        chk("default_seg_o", (q % 8 == 4 || (q % 8 == 5 && f > 0)) ? 3 : 2, default_seg_o ^ 3'h1);
      end
    end
    // Scale stays 00 here because the index field says no index register.
    send(1'b0, 1'b1, 1'b0, 1'b0, 8'h44, 8'h25, 3'h0, 2'h0);
    chk("sib_follows_o", 1'b0, sib_follows_o);
    send(1'b1, 1'b1, 1'b0, 1'b0, 8'hc4, 8'h25, 3'h0, 2'h0);
    chk("sib_follows_o", 1'b0, sib_follows_o);
    send(1'b1, 1'b1, 1'b0, 1'b0, 8'h44, 8'h25, 3'h0, 2'h0);
    @(posedge clk_i);
    #1;
    chk("valid_o", 1'b0, valid_o);
    chk("disp_o", ofd_pkg::OFD_DISP_8, disp_o);
  endtask : t_sib
  // A reset in mid-run clears the held decode, and the next request is taken at once.
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("sib_follows_o", 1'b0, sib_follows_o);
    chk("disp_o", ofd_pkg::OFD_DISP_NONE, disp_o);
    chk("default_seg_o", ofd_pkg::OFD_SEG_DS, default_seg_o);
    @(posedge clk_i);
    rst_i <= 1'b0;
    send(1'b1, 1'b1, 1'b0, 1'b0, 8'h84, 8'h25, 3'h0, 2'h0);
    chk("disp_o", ofd_pkg::OFD_DISP_32, disp_o);
    chk("default_seg_o", ofd_pkg::OFD_SEG_SS, default_seg_o);
  endtask : t_reset
  task automatic print_verdict;
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // Reset for five edges, then every scenario in turn.
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    chk("default_seg_o", ofd_pkg::OFD_SEG_DS, default_seg_o);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rm();
    t_reg();
    t_seg();
    t_sib();
    t_reset();
    print_verdict();
  end
  // A hang is cut short and counted.
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule : ofd_decoder_tb_top
